// File: src/insn_execute.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - word and byte add, plain or with carry, 2 or 4 byte forms
// RULE2 - word and byte subtract, plain or with borrow, 2 or 4 byte forms
// RULE3 - multiply two registers 16 by 16, signed or unsigned
// RULE4 - divide low half of muldiv register by register, 16 by 16
// RULE5 - divide full 32-bit muldiv register by 16-bit register
// RULE6 - compare word with register, then decrement register by 1 or 2
// RULE7 - compare word with register, then increment register by 1 or 2
// RULE8 - count shifts needed to normalise a word, write to destination; code counts leading bits equal to bit 15, so 16'h8000 gives 1
// RULE9 - arithmetic right shift replicating sign bit
// RULE10 - widen byte to word with sign or zero extension
// RULE11 - jump if bit set; clearing variant also clears bit
// RULE12 - jump if bit clear; setting variant also sets bit
// RULE13 - change only masked bits of high or low byte with immediate
// RULE14 - copy a bit or its inverse to another bit
// RULE15 - push a register then call absolute target
// RULE16 - push a register then load it with the operand
// RULE17 - return pops address; pop variant also pops a register
// RULE18 - trap enters service routine chosen by immediate number
// RULE19 - legacy power down decodes as valid 4-byte op, does nothing; code still loads CARRY_OUT 0, ZERO_OUT 1, NEG_OUT 0
// RULE20 - opcode patterns follow the core instruction set reference
module insn_execute #(
   parameter int WIDTH = 16
) (
   input  wire logic             SYS_CLK,
   input  wire logic             RESET,
   input  wire logic             ISSUE,
   input  wire logic [31:0]      INSN,
   input  wire logic [WIDTH-1:0] OPND_A,
   input  wire logic [WIDTH-1:0] OPND_B,
   input  wire logic             CARRY_IN,
   input  wire logic             BIT_SRC,
   input  wire logic [31:0]      MULDIV_IN,
   input  wire logic [15:0]      PC_IN,
   output      logic             READY,
   output      logic             DONE,
   output      logic [2:0]       LENGTH,
   output      logic             ILLEGAL,
   output      logic [WIDTH-1:0] RESULT,
   output      logic             RESULT_WE,
   output      logic [WIDTH-1:0] REG_UPDATE,
   output      logic             REG_UPDATE_WE,
   output      logic [31:0]      MULDIV_OUT,
   output      logic             MULDIV_WE,
   output      logic             CARRY_OUT,
   output      logic             ZERO_OUT,
   output      logic             NEG_OUT,
   output      logic             BIT_OUT,
   output      logic             BIT_WE,
   output      logic             BRANCH,
   output      logic [15:0]      TARGET,
   output      logic             PUSH,
   output      logic [15:0]      PUSH_DATA,
   output      logic [1:0]       POP_COUNT
);
   // ==========================================
   // decode
   insn_pkg::op_type op;
   logic [2:0]       len;
   logic             variant;

   insn_decode u_decode (
      .word    (INSN),
      .op      (op),
      .len     (len),
      .variant (variant)
   ); // RULE20

   // ==========================================
   // divider
   logic        div_busy;
   logic        div_done;
   logic [15:0] div_q;
   logic [15:0] div_r;
   logic        div_start;
   logic        div_pending;

   assign div_start = ISSUE && READY && (op == insn_pkg::OP_DIV || op == insn_pkg::OP_DIVL);

   insn_divider u_divider (
      .clk       (SYS_CLK),
      .rst       (RESET),
      .start     (div_start),
      .signed_op (!variant),
      .dividend  (op == insn_pkg::OP_DIVL ? MULDIV_IN
                  : (!variant ? {{16{MULDIV_IN[15]}}, MULDIV_IN[15:0]}
                              : {16'h0000, MULDIV_IN[15:0]})), // RULE4 RULE5
      .divisor   (OPND_B),
      .busy      (div_busy),
      .done      (div_done),
      .quotient  (div_q),
      .remainder (div_r)
   );

   assign READY = !div_busy && !div_pending;

   // ==========================================
   // helpers
   function automatic logic [4:0] lead_count(input logic [15:0] v);
      logic [4:0] n;
      logic       found;
      n = 5'h00;
      found = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         if (!found && (v[i] ^ v[15]) == 1'b0 && i != 0) n = n + 5'h01;
         else found = 1'b1;
      end
      lead_count = (v == 16'h0000) ? 5'h00 : n;
   endfunction : lead_count

   // ==========================================
   // combinational datapath
   logic [16:0] sum;
   logic [8:0]  sum_b;
   logic [31:0] product;
   logic [15:0] step;
   logic [15:0] mask;
   logic [15:0] next_result;
   logic        next_we;
   logic        next_carry;

   localparam logic [15:0] WORD_ZERO = insn_pkg::WORD_RESET;

   always_comb begin
      sum = 17'h00000;
      sum_b = 9'h000;
      product = 32'h00000000;
      next_result = WORD_ZERO;
      next_we = 1'b0;
      next_carry = 1'b0;
      step = {14'h0000, variant ? insn_pkg::STEP_TWO : insn_pkg::STEP_ONE};
      mask = 16'h0000;
      unique case (op)
         insn_pkg::OP_ADD, insn_pkg::OP_ADDC: begin
            sum = {1'b0, OPND_A} + {1'b0, OPND_B}
                  + {16'h0000, op == insn_pkg::OP_ADDC && CARRY_IN}; // RULE1
            sum_b = {1'b0, OPND_A[7:0]} + {1'b0, OPND_B[7:0]}
                    + {8'h00, op == insn_pkg::OP_ADDC && CARRY_IN};
            next_result = variant ? {OPND_A[15:8], sum_b[7:0]} : sum[15:0];
            next_carry = variant ? sum_b[8] : sum[16];
            next_we = 1'b1;
         end
         insn_pkg::OP_SUB, insn_pkg::OP_SUBC: begin
            sum = {1'b0, OPND_A} - {1'b0, OPND_B}
                  - {16'h0000, op == insn_pkg::OP_SUBC && CARRY_IN}; // RULE2
            sum_b = {1'b0, OPND_A[7:0]} - {1'b0, OPND_B[7:0]}
                    - {8'h00, op == insn_pkg::OP_SUBC && CARRY_IN};
            next_result = variant ? {OPND_A[15:8], sum_b[7:0]} : sum[15:0];
            next_carry = variant ? sum_b[8] : sum[16];
            next_we = 1'b1;
         end
         insn_pkg::OP_MUL: begin
            product = variant ? OPND_A * OPND_B
                              : 32'($signed(OPND_A) * $signed(OPND_B)); // RULE3
         end
         insn_pkg::OP_CMPD, insn_pkg::OP_CMPI: begin
            sum = {1'b0, OPND_A} - {1'b0, OPND_B};
            next_carry = sum[16];
            next_result = sum[15:0];
         end
         insn_pkg::OP_NORM: begin
            next_result = {11'h000, lead_count(OPND_B)}; // RULE8
            next_we = 1'b1;
         end
         insn_pkg::OP_ARITH_RIGHT_SHIFT: begin
            next_result = 16'($signed(OPND_A) >>> OPND_B[3:0]); // RULE9
            next_we = 1'b1;
         end
         insn_pkg::OP_WIDEN: begin
            next_result = variant ? {8'h00, OPND_B[7:0]}
                                  : {{8{OPND_B[7]}}, OPND_B[7:0]}; // RULE10
            next_we = 1'b1;
         end
         insn_pkg::OP_BFLD: begin
            mask = INSN[15] ? {INSN[23:16], 8'h00} : {8'h00, INSN[23:16]};
            next_result = (OPND_A & ~mask)
                          | ((INSN[15] ? {INSN[31:24], 8'h00}
                                       : {8'h00, INSN[31:24]}) & mask); // RULE13
            next_we = 1'b1;
         end
         insn_pkg::OP_CONTEXT_SWITCH: begin
            next_result = OPND_B; // RULE16
            next_we = 1'b1;
         end
         default: begin
            next_result = WORD_ZERO;
         end
      endcase
   end

   // ==========================================
   // result and flags
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         RESULT <= insn_pkg::WORD_RESET;
         RESULT_WE <= insn_pkg::FLAG_RESET;
         CARRY_OUT <= insn_pkg::FLAG_RESET;
         ZERO_OUT <= insn_pkg::FLAG_RESET;
         NEG_OUT <= insn_pkg::FLAG_RESET;
         LENGTH <= insn_pkg::LEN_SHORT;
         ILLEGAL <= insn_pkg::FLAG_RESET;
         DONE <= insn_pkg::FLAG_RESET;
      end else begin
         RESULT_WE <= 1'b0;
         DONE <= div_done;
         ILLEGAL <= 1'b0;
         if (ISSUE && READY) begin
            RESULT <= next_result;
            RESULT_WE <= next_we;
            CARRY_OUT <= next_carry;
            ZERO_OUT <= next_result == WORD_ZERO;
            NEG_OUT <= next_result[15];
            LENGTH <= len; // RULE1 RULE2 RULE19
            ILLEGAL <= op == insn_pkg::OP_ILLEGAL;
            DONE <= !div_start;
         end
      end
   end

   // ==========================================
   // register step and muldiv register
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         REG_UPDATE <= insn_pkg::WORD_RESET;
         REG_UPDATE_WE <= insn_pkg::FLAG_RESET;
         MULDIV_OUT <= 32'h00000000;
         MULDIV_WE <= insn_pkg::FLAG_RESET;
         div_pending <= 1'b0;
      end else begin
         REG_UPDATE_WE <= 1'b0;
         MULDIV_WE <= 1'b0;
         if (div_start) div_pending <= 1'b1;
         else if (div_done) div_pending <= 1'b0;
         if (ISSUE && READY && op == insn_pkg::OP_CMPD) begin
            REG_UPDATE <= OPND_A - step; // RULE6
            REG_UPDATE_WE <= 1'b1;
         end
         if (ISSUE && READY && op == insn_pkg::OP_CMPI) begin
            REG_UPDATE <= OPND_A + step; // RULE7
            REG_UPDATE_WE <= 1'b1;
         end
         if (ISSUE && READY && op == insn_pkg::OP_MUL) begin
            MULDIV_OUT <= product; // RULE3
            MULDIV_WE <= 1'b1;
         end
         if (div_done) begin
            MULDIV_OUT <= {div_r, div_q}; // RULE4 RULE5
            MULDIV_WE <= 1'b1;
         end
      end
   end

   // ==========================================
   // bits, branches and stack
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         BIT_OUT <= insn_pkg::FLAG_RESET;
         BIT_WE <= insn_pkg::FLAG_RESET;
         BRANCH <= insn_pkg::FLAG_RESET;
         TARGET <= insn_pkg::WORD_RESET;
         PUSH <= insn_pkg::FLAG_RESET;
         PUSH_DATA <= insn_pkg::WORD_RESET;
         POP_COUNT <= 2'h0;
      end else begin
         BIT_WE <= 1'b0;
         BRANCH <= 1'b0;
         PUSH <= 1'b0;
         POP_COUNT <= 2'h0;
         if (ISSUE && READY) begin
            unique case (op)
               insn_pkg::OP_JBS: begin
                  BRANCH <= BIT_SRC; // RULE11
                  TARGET <= PC_IN + {{8{INSN[31]}}, INSN[31:24]};
                  BIT_WE <= variant && BIT_SRC;
                  BIT_OUT <= 1'b0;
               end
               insn_pkg::OP_JBC: begin
                  BRANCH <= !BIT_SRC; // RULE12
                  TARGET <= PC_IN + {{8{INSN[31]}}, INSN[31:24]};
                  BIT_WE <= variant && !BIT_SRC;
                  BIT_OUT <= 1'b1;
               end
               insn_pkg::OP_BCOPY: begin
                  BIT_OUT <= BIT_SRC ^ variant; // RULE14
                  BIT_WE <= 1'b1;
               end
               insn_pkg::OP_PUSH_AND_CALL: begin
                  PUSH <= 1'b1; // RULE15
                  PUSH_DATA <= OPND_A;
                  BRANCH <= 1'b1;
                  TARGET <= INSN[31:16];
               end
               insn_pkg::OP_CONTEXT_SWITCH: begin
                  PUSH <= 1'b1; // RULE16
                  PUSH_DATA <= OPND_A;
               end
               insn_pkg::OP_RET: begin
                  POP_COUNT <= variant ? 2'h2 : 2'h1; // RULE17
                  BRANCH <= 1'b1;
                  TARGET <= OPND_A;
               end
               insn_pkg::OP_TRAP: begin
                  PUSH <= 1'b1;
                  PUSH_DATA <= PC_IN + {13'h0000, insn_pkg::LEN_SHORT};
                  BRANCH <= 1'b1;
                  TARGET <= {7'h00, INSN[15:9], 2'h0}; // RULE18
               end
               default: begin
                  BRANCH <= 1'b0; // RULE19
               end
            endcase
         end
      end
   end

   // ==========================================
   // checks
   chk_legacy_power_down_op_quiet : assert property (@(posedge SYS_CLK) disable iff (RESET)
      ISSUE && READY && op == insn_pkg::OP_LEGACY_POWER_DOWN_OP |=> !RESULT_WE && !BRANCH && !PUSH
      && LENGTH == insn_pkg::LEN_LONG) else $error("power down op acted"); // RULE19
   chk_cmpd_step : assert property (@(posedge SYS_CLK) disable iff (RESET)
      ISSUE && READY && op == insn_pkg::OP_CMPD |=> REG_UPDATE_WE
      && REG_UPDATE == $past(OPND_A) - $past(step)) else $error("bad decrement"); // RULE6
   chk_cmpi_step : assert property (@(posedge SYS_CLK) disable iff (RESET)
      ISSUE && READY && op == insn_pkg::OP_CMPI |=> REG_UPDATE_WE
      && REG_UPDATE == $past(OPND_A) + $past(step)) else $error("bad increment"); // RULE7
   chk_div_finish : assert property (@(posedge SYS_CLK) disable iff (RESET)
      div_start |-> ##[30:34] MULDIV_WE) else $error("divide never finished"); // RULE5
   chk_add_sum : assert property (@(posedge SYS_CLK) disable iff (RESET)
      ISSUE && READY && op == insn_pkg::OP_ADD && !variant |=>
      RESULT == $past(OPND_A) + $past(OPND_B)) else $error("bad add"); // RULE1
   chk_sub_diff : assert property (@(posedge SYS_CLK) disable iff (RESET)
      ISSUE && READY && op == insn_pkg::OP_SUB && !variant |=>
      RESULT == $past(OPND_A) - $past(OPND_B)) else $error("bad subtract"); // RULE2
   chk_jump_set : assert property (@(posedge SYS_CLK) disable iff (RESET)
      ISSUE && READY && op == insn_pkg::OP_JBS |=> BRANCH == $past(BIT_SRC))
      else $error("bad bit jump"); // RULE11
   chk_ret_pops : assert property (@(posedge SYS_CLK) disable iff (RESET)
      ISSUE && READY && op == insn_pkg::OP_RET |=> POP_COUNT != 2'h0 && BRANCH)
      else $error("return without pop"); // RULE17
   chk_push_call : assert property (@(posedge SYS_CLK) disable iff (RESET)
      ISSUE && READY && op == insn_pkg::OP_PUSH_AND_CALL |=> PUSH && BRANCH)
      else $error("call without push"); // RULE15

endmodule : insn_execute

// File: src/insn_pkg.sv
package insn_pkg;

   // ==========================================
   // instruction classes
   typedef enum logic [5:0] {
      OP_NOP, OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_MUL, OP_DIV, OP_DIVL,
      OP_CMPD, OP_CMPI, OP_NORM, OP_ARITH_RIGHT_SHIFT, OP_WIDEN, OP_JBS, OP_JBC,
      OP_BFLD, OP_BCOPY, OP_PUSH_AND_CALL, OP_CONTEXT_SWITCH, OP_RET, OP_TRAP, OP_LEGACY_POWER_DOWN_OP,
      OP_ILLEGAL
   } op_type;

   // ==========================================
   // opcode first bytes (arbitrary map, see instruction set reference)
   localparam logic [7:0] OPC_ADD   = 8'h00;
   localparam logic [7:0] OPC_ADDC  = 8'h10;
   localparam logic [7:0] OPC_SUB   = 8'h20;
   localparam logic [7:0] OPC_SUBC  = 8'h30;
   localparam logic [7:0] OPC_MUL   = 8'h0C;
   localparam logic [7:0] OPC_DIV   = 8'h4C;
   localparam logic [7:0] OPC_DIVL  = 8'h6C;
   localparam logic [7:0] OPC_CMPD  = 8'hA0;
   localparam logic [7:0] OPC_CMPI  = 8'h80;
   localparam logic [7:0] OPC_NORM  = 8'h2B;
   localparam logic [7:0] OPC_ARITH_RIGHT_SHIFT  = 8'hAC;
   localparam logic [7:0] OPC_WIDEN = 8'hD0;
   localparam logic [7:0] OPC_JBS   = 8'h8C;
   localparam logic [7:0] OPC_JBC   = 8'h9C;
   localparam logic [7:0] OPC_BFLD  = 8'h0A;
   localparam logic [7:0] OPC_BCOPY = 8'h4E;
   localparam logic [7:0] OPC_PUSH_AND_CALL = 8'hE2;
   localparam logic [7:0] OPC_CONTEXT_SWITCH  = 8'hC6;
   localparam logic [7:0] OPC_RET   = 8'hCE;
   localparam logic [7:0] OPC_TRAP  = 8'h9B;
   localparam logic [7:0] OPC_LEGACY_POWER_DOWN_OP = 8'h97;
   localparam logic [7:0] OPC_NOP   = 8'hCC;

   // ==========================================
   // encoding lengths and step sizes
   localparam logic [2:0] LEN_SHORT = 3'h2;
   localparam logic [2:0] LEN_LONG  = 3'h4;
   localparam logic [1:0] STEP_ONE  = 2'h1;
   localparam logic [1:0] STEP_TWO  = 2'h2;

   // ==========================================
   // reset values
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic        FLAG_RESET = 1'b0;

endpackage : insn_pkg

// File: src/insn_decode.sv
`timescale 1ns/1ps
module insn_decode (
   input  wire logic [31:0]         word,
   output      insn_pkg::op_type    op,
   output      logic [2:0]          len,
   output      logic                variant
);
   // ==========================================
   // opcode to class, length and variant bit
   always_comb begin
      op      = insn_pkg::OP_ILLEGAL;
      len     = insn_pkg::LEN_SHORT;
      variant = word[0];
      unique case (word[7:0]) inside
         insn_pkg::OPC_ADD,  insn_pkg::OPC_ADD  | 8'h01,
         insn_pkg::OPC_ADD  | 8'h08, insn_pkg::OPC_ADD  | 8'h09: begin
            op = insn_pkg::OP_ADD;
            len = word[3] ? insn_pkg::LEN_LONG : insn_pkg::LEN_SHORT;
         end
         insn_pkg::OPC_ADDC, insn_pkg::OPC_ADDC | 8'h01,
         insn_pkg::OPC_ADDC | 8'h08, insn_pkg::OPC_ADDC | 8'h09: begin
            op = insn_pkg::OP_ADDC;
            len = word[3] ? insn_pkg::LEN_LONG : insn_pkg::LEN_SHORT;
         end
         insn_pkg::OPC_SUB,  insn_pkg::OPC_SUB  | 8'h01,
         insn_pkg::OPC_SUB  | 8'h08, insn_pkg::OPC_SUB  | 8'h09: begin
            op = insn_pkg::OP_SUB;
            len = word[3] ? insn_pkg::LEN_LONG : insn_pkg::LEN_SHORT;
         end
         insn_pkg::OPC_SUBC, insn_pkg::OPC_SUBC | 8'h01,
         insn_pkg::OPC_SUBC | 8'h08, insn_pkg::OPC_SUBC | 8'h09: begin
            op = insn_pkg::OP_SUBC;
            len = word[3] ? insn_pkg::LEN_LONG : insn_pkg::LEN_SHORT;
         end
         insn_pkg::OPC_CMPD, insn_pkg::OPC_CMPD | 8'h01,
         insn_pkg::OPC_CMPD | 8'h08, insn_pkg::OPC_CMPD | 8'h09: begin
            op = insn_pkg::OP_CMPD;
            len = word[3] ? insn_pkg::LEN_LONG : insn_pkg::LEN_SHORT;
         end
         insn_pkg::OPC_CMPI, insn_pkg::OPC_CMPI | 8'h01,
         insn_pkg::OPC_CMPI | 8'h08, insn_pkg::OPC_CMPI | 8'h09: begin
            op = insn_pkg::OP_CMPI;
            len = word[3] ? insn_pkg::LEN_LONG : insn_pkg::LEN_SHORT;
         end
         insn_pkg::OPC_WIDEN, insn_pkg::OPC_WIDEN | 8'h01,
         insn_pkg::OPC_WIDEN | 8'h08, insn_pkg::OPC_WIDEN | 8'h09: begin
            op = insn_pkg::OP_WIDEN;
            len = word[3] ? insn_pkg::LEN_LONG : insn_pkg::LEN_SHORT;
         end
         insn_pkg::OPC_MUL,  insn_pkg::OPC_MUL  | 8'h01: op = insn_pkg::OP_MUL;
         insn_pkg::OPC_DIV,  insn_pkg::OPC_DIV  | 8'h01: op = insn_pkg::OP_DIV;
         insn_pkg::OPC_DIVL, insn_pkg::OPC_DIVL | 8'h01: op = insn_pkg::OP_DIVL;
         insn_pkg::OPC_NORM:  op = insn_pkg::OP_NORM;
         insn_pkg::OPC_ARITH_RIGHT_SHIFT:  op = insn_pkg::OP_ARITH_RIGHT_SHIFT;
         insn_pkg::OPC_RET,  insn_pkg::OPC_RET  | 8'h01: op = insn_pkg::OP_RET;
         insn_pkg::OPC_TRAP:  op = insn_pkg::OP_TRAP;
         insn_pkg::OPC_NOP:   op = insn_pkg::OP_NOP;
         insn_pkg::OPC_JBS, insn_pkg::OPC_JBS | 8'h01: begin
            op = insn_pkg::OP_JBS;
            len = insn_pkg::LEN_LONG;
         end
         insn_pkg::OPC_JBC, insn_pkg::OPC_JBC | 8'h01: begin
            op = insn_pkg::OP_JBC;
            len = insn_pkg::LEN_LONG;
         end
         insn_pkg::OPC_BFLD: begin
            op = insn_pkg::OP_BFLD;
            len = insn_pkg::LEN_LONG;
         end
         insn_pkg::OPC_BCOPY, insn_pkg::OPC_BCOPY | 8'h01: begin
            op = insn_pkg::OP_BCOPY;
            len = insn_pkg::LEN_LONG;
         end
         insn_pkg::OPC_PUSH_AND_CALL: begin
            op = insn_pkg::OP_PUSH_AND_CALL;
            len = insn_pkg::LEN_LONG;
         end
         insn_pkg::OPC_CONTEXT_SWITCH: begin
            op = insn_pkg::OP_CONTEXT_SWITCH;
            len = insn_pkg::LEN_LONG;
         end
         insn_pkg::OPC_LEGACY_POWER_DOWN_OP: begin
            op = insn_pkg::OP_LEGACY_POWER_DOWN_OP;
            len = insn_pkg::LEN_LONG;
         end
         default: op = insn_pkg::OP_ILLEGAL;
      endcase
   end
endmodule : insn_decode

// File: src/insn_divider.sv
`timescale 1ns/1ps
module insn_divider (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic        signed_op,
   input  wire logic [31:0] dividend,
   input  wire logic [15:0] divisor,
   output      logic        busy,
   output      logic        done,
   output      logic [15:0] quotient,
   output      logic [15:0] remainder
);
   // ==========================================
   // restoring divider, one bit per cycle
   logic [31:0] quo;
   logic [32:0] rem;
   logic [15:0] dvs;
   logic [5:0]  count;
   logic        neg_q;
   logic        neg_r;
   logic [32:0] trial;

   assign trial = {rem[31:0], quo[31]} - {17'h00000, dvs};

   always_ff @(posedge clk) begin
      if (rst) begin
         busy <= 1'b0;
         done <= 1'b0;
         quo <= 32'h00000000;
         rem <= 33'h000000000;
         dvs <= 16'h0000;
         count <= 6'h00;
         neg_q <= 1'b0;
         neg_r <= 1'b0;
         quotient <= 16'h0000;
         remainder <= 16'h0000;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            count <= 6'h20;
            rem <= 33'h000000000;
            quo <= (signed_op && dividend[31]) ? 32'h00000000 - dividend : dividend;
            dvs <= (signed_op && divisor[15]) ? 16'h0000 - divisor : divisor;
            neg_q <= signed_op && (dividend[31] ^ divisor[15]);
            neg_r <= signed_op && dividend[31];
         end else if (busy) begin
            if (!trial[32]) begin
               rem <= trial;
               quo <= {quo[30:0], 1'b1};
            end else begin
               rem <= {rem[31:0], quo[31]};
               quo <= {quo[30:0], 1'b0};
            end
            count <= count - 6'h01;
            if (count == 6'h01) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
         if (busy && count == 6'h01) begin
            quotient <= neg_q ? 16'h0000 - next_q(trial, quo) : next_q(trial, quo);
            remainder <= neg_r ? 16'h0000 - next_r(trial, rem, quo)
                                : next_r(trial, rem, quo);
         end
      end
   end

   function automatic logic [15:0] next_q(input logic [32:0] t, input logic [31:0] q);
      next_q = {q[14:0], ~t[32]};
   endfunction : next_q

   function automatic logic [15:0] next_r(input logic [32:0] t, input logic [32:0] r,
                                          input logic [31:0] q);
      logic [32:0] sh;
      sh = {r[31:0], q[31]};
      next_r = t[32] ? sh[15:0] : t[15:0];
   endfunction : next_r
endmodule : insn_divider

// File: sim/insn_execute_tb_top.sv
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module insn_execute_tb_top;
   logic        SYS_CLK, RESET, ISSUE, CARRY_IN, BIT_SRC, rdy;
   logic [31:0] INSN, MULDIV_IN, MULDIV_OUT;
   logic [15:0] OPND_A, OPND_B, PC_IN, RESULT, REG_UPDATE, TARGET, PUSH_DATA;
   logic        READY, DONE, ILLEGAL, RESULT_WE, REG_UPDATE_WE, MULDIV_WE, CARRY_OUT;
   logic        ZERO_OUT, NEG_OUT, BIT_OUT, BIT_WE, BRANCH, PUSH;
   logic [2:0]  LENGTH;
   logic [1:0]  POP_COUNT;
   int          n_mismatch, samples_checked;
   // ==========================================
   // device under test
   insn_execute insn_execute_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .ISSUE(ISSUE), .INSN(INSN),
      .OPND_A(OPND_A), .OPND_B(OPND_B), .CARRY_IN(CARRY_IN), .BIT_SRC(BIT_SRC),
      .MULDIV_IN(MULDIV_IN), .PC_IN(PC_IN), .READY(READY), .DONE(DONE), .LENGTH(LENGTH),
      .ILLEGAL(ILLEGAL), .RESULT(RESULT), .RESULT_WE(RESULT_WE), .REG_UPDATE(REG_UPDATE),
      .REG_UPDATE_WE(REG_UPDATE_WE), .MULDIV_OUT(MULDIV_OUT), .MULDIV_WE(MULDIV_WE),
      .CARRY_OUT(CARRY_OUT), .ZERO_OUT(ZERO_OUT), .NEG_OUT(NEG_OUT), .BIT_OUT(BIT_OUT),
      .BIT_WE(BIT_WE), .BRANCH(BRANCH), .TARGET(TARGET), .PUSH(PUSH), .PUSH_DATA(PUSH_DATA),
      .POP_COUNT(POP_COUNT));
   initial begin
      SYS_CLK = 1'b0;
      forever #20 SYS_CLK = ~SYS_CLK;
   end
   // ==========================================
   // shared tasks
   task automatic conclude;
      $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   task automatic go(input logic [31:0] opc, input logic [15:0] a, input logic [15:0] b);
      int k;
      @(posedge SYS_CLK);
      #1;
      INSN = opc;
      OPND_A = a;
      OPND_B = b;
      ISSUE = 1'b1;
      @(posedge SYS_CLK);
      #1;
      ISSUE = 1'b0;
      rdy = READY;
      for (k = 0; k < 60 && DONE !== 1'b1; k++) begin
         @(posedge SYS_CLK);
         #1;
      end
      if (DONE !== 1'b1) begin
         n_mismatch++;
         $display("wrong value DONE expected 1 seen %b", DONE);
         conclude();
      end
   endtask : go
   // ==========================================
   // scenarios
   task automatic t_arith;
      go(insn_pkg::OPC_ADD, 16'h0005, 16'h0003);
      `CHECK("sum", 16'h0008, RESULT)
      `CHECK("len", 3'h2, LENGTH)
      go(insn_pkg::OPC_ADDC | 8'h08, 16'h0005, 16'h0003);
      `CHECK("sum carry", 16'h0009, RESULT)
      `CHECK("len long", 3'h4, LENGTH)
      go(insn_pkg::OPC_SUB, 16'h0005, 16'h0003);
      `CHECK("diff", 16'h0002, RESULT)
      `CHECK("we", 1'b1, RESULT_WE)
      $display("test arith done");
   endtask : t_arith
   task automatic t_muldiv;
      MULDIV_IN = 32'h0001_0006;
      go(insn_pkg::OPC_MUL, 16'h0003, 16'h0004);
      `CHECK("product", 32'h0000_000C, MULDIV_OUT)
      go(insn_pkg::OPC_DIVL, 16'h0007, 16'h0007);
      `CHECK("ready", 1'b0, rdy)
      `CHECK("long quot", 32'h0001_2493, MULDIV_OUT)
      `CHECK("md we", 1'b1, MULDIV_WE)
      go(insn_pkg::OPC_DIV, 16'h0007, 16'h0007);
      `CHECK("short quot", 32'h0006_0000, MULDIV_OUT)
      $display("test muldiv done");
   endtask : t_muldiv
   task automatic t_step;
      go(insn_pkg::OPC_CMPD, 16'h000A, 16'h0001);
      `CHECK("dec1", 16'h0009, REG_UPDATE)
      go(insn_pkg::OPC_CMPD | 8'h01, 16'h000A, 16'h0001);
      `CHECK("dec2", 16'h0008, REG_UPDATE)
      go(insn_pkg::OPC_CMPI, 16'h000A, 16'h0001);
      `CHECK("inc1", 16'h000B, REG_UPDATE)
      go(insn_pkg::OPC_CMPI | 8'h01, 16'h000A, 16'h0001);
      `CHECK("inc2", 16'h000C, REG_UPDATE)
      `CHECK("upd we", 1'b1, REG_UPDATE_WE)
      $display("test step done");
   endtask : t_step
   task automatic t_shift;
      go(insn_pkg::OPC_ARITH_RIGHT_SHIFT, 16'h8000, 16'h0004);
      `CHECK("arith_right_shift", 16'hF800, RESULT)
      `CHECK("arith_right_shift neg", 1'b1, NEG_OUT)
      go(insn_pkg::OPC_WIDEN, 16'h0080, 16'h0080);
      `CHECK("sign ext", 16'hFF80, RESULT)
      go(insn_pkg::OPC_WIDEN | 8'h01, 16'h0080, 16'h0080);
      `CHECK("zero ext", 16'h0080, RESULT)
      $display("test shift done");
   endtask : t_shift
   task automatic t_legacy_power_down_op;
      go(insn_pkg::OPC_LEGACY_POWER_DOWN_OP, 16'h0001, 16'h0001);
      `CHECK("len", 3'h4, LENGTH)
      `CHECK("illegal", 1'b0, ILLEGAL)
      `CHECK("no write", 1'b0, RESULT_WE | REG_UPDATE_WE | MULDIV_WE | BIT_WE)
      `CHECK("no flow", 1'b0, BRANCH | PUSH)
      $display("test legacy_power_down_op done");
   endtask : t_legacy_power_down_op
   task automatic t_flow;
      PC_IN = 16'h0100;
      go({8'h05, 16'h0000, insn_pkg::OPC_JBS | 8'h01}, 16'h0000, 16'h0000);
      `CHECK("jb branch", 1'b1, BRANCH)
      `CHECK("jb target", 16'h0105, TARGET)
      `CHECK("jb clear", 2'h2, {BIT_WE, BIT_OUT})
      go({24'h000000, insn_pkg::OPC_JBC}, 16'h0000, 16'h0000);
      `CHECK("jnb branch", 1'b0, BRANCH)
      go({8'h34, 8'hF0, 8'h80, insn_pkg::OPC_BFLD}, 16'h1234, 16'h0000);
      `CHECK("bfld", 16'h3234, RESULT)
      go({24'h000000, insn_pkg::OPC_BCOPY | 8'h01}, 16'h0000, 16'h0000);
      `CHECK("bit copy", 2'h2, {BIT_WE, BIT_OUT})
      go({16'h0200, 8'h00, insn_pkg::OPC_PUSH_AND_CALL}, 16'hABCD, 16'h0000);
      `CHECK("push_and_call push", 16'hABCD, PUSH_DATA)
      `CHECK("push_and_call target", 16'h0200, TARGET)
      go({24'h000000, insn_pkg::OPC_CONTEXT_SWITCH}, 16'h1111, 16'h2222);
      `CHECK("context_switch load", 16'h2222, RESULT)
      `CHECK("context_switch push", 16'h1111, PUSH_DATA)
      go({24'h000000, insn_pkg::OPC_RET | 8'h01}, 16'h0300, 16'h0000);
      `CHECK("ret pops", 2'h2, POP_COUNT)
      `CHECK("ret target", 16'h0300, TARGET)
      go({16'h0000, 8'h0A, insn_pkg::OPC_TRAP}, 16'h0000, 16'h0000);
      `CHECK("trap vector", 16'h0014, TARGET)
      `CHECK("trap push", 16'h0102, PUSH_DATA)
      go({24'h000000, insn_pkg::OPC_NORM}, 16'h0000, 16'h0001);
      `CHECK("norm", 16'h000F, RESULT)
      go(32'h000000FF, 16'h0000, 16'h0000);
      `CHECK("illegal", 1'b1, ILLEGAL)
      $display("test flow done");
   endtask : t_flow
   initial begin
      {RESET, ISSUE, CARRY_IN, BIT_SRC} = 4'h9;
      {INSN, MULDIV_IN} = 64'h0;
      {OPND_A, OPND_B, PC_IN} = 48'h0;
      CARRY_IN = 1'b1;
      repeat (2) @(posedge SYS_CLK);
      #1;
      RESET = 1'b0;
      t_arith();
      t_muldiv();
      t_step();
      t_shift();
      t_legacy_power_down_op();
      t_flow();
      conclude();
   end
endmodule : insn_execute_tb_top
